/* tmo_consts.svh */
// Constants for the TLB maintenance unit: offsets, fields, opcodes
`ifndef TMO_CONSTS_SVH
`define TMO_CONSTS_SVH

// ****************************************************************
// APB register offsets
// ****************************************************************
`define TMO_A_ENTRY_HIGH 8'h00
`define TMO_A_LOW_EVEN 8'h04
`define TMO_A_LOW_ODD 8'h08
`define TMO_A_PAGE_MASK 8'h0C
`define TMO_A_INDEX 8'h10
`define TMO_A_RANDOM 8'h14
`define TMO_A_CTRL 8'h18

// ****************************************************************
// Write masks and reset values
// ****************************************************************
`define TMO_WM_HIGH 32'hFFFFE0FF
`define TMO_WM_LOW 32'h03FFFFFF
`define TMO_WM_MASK 32'h01FFE000
`define TMO_WM_INDEX 32'h0000003F
`define TMO_RST_WORD 32'h00000000
`define TMO_ZERO_W 32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define TMO_VPN_HI 31
`define TMO_VPN_LO 13
`define TMO_ASID_HI 7
`define TMO_PM_HI 24
`define TMO_LO_HI 25
`define TMO_G_BIT 0
`define TMO_PROBE_FAIL 31
`define TMO_IDX_HI 5
`define TMO_CTRL_CU 0

// ****************************************************************
// Instruction encoding
// ****************************************************************
`define TMO_OPC_SYS 6'h10
`define TMO_ZERO19 19'h00000
`define TMO_FN_PROBE 6'h08
`define TMO_FN_READ 6'h01
`define TMO_FN_WIDX 6'h02
`define TMO_FN_WRND 6'h06

`endif

/* tmo_pkg.sv */
// Types shared by the TLB maintenance unit
package tmo_pkg;
`include "tmo_consts.svh"

   typedef enum logic [2:0] {
      OP_NONE,
      OP_PROBE,
      OP_READ,
      OP_WIDX,
      OP_WRND
   } tmo_op_e;

   // One stored TLB entry; lo fields hold staging bits 25..1
   typedef struct packed {
      logic [`TMO_PM_HI-`TMO_VPN_LO:0] mask;
      logic [`TMO_VPN_HI-`TMO_VPN_LO:0] vpn;
      logic [`TMO_ASID_HI:0] asid;
      logic g;
      logic [`TMO_LO_HI-1:0] lo1;
      logic [`TMO_LO_HI-1:0] lo0;
   } tmo_entry_s;

endpackage

/* tmo_match.sv */
// One TLB entry comparator for the probe search
`timescale 1ns/1ns
module tmo_match (
   // Stored entry
   input wire tmo_pkg::tmo_entry_s entry,
   // Search key from entry high
   input wire logic [18:0] vpn,
   input wire logic [7:0] asid,
   // Result
   output logic hit
);
   import tmo_pkg::*;

   logic [18:0] care;

   // Page mask bits widen the page, so they drop out of the compare
   assign care = ~{7'h00, entry.mask};
   assign hit = ((entry.vpn & care) == (vpn & care)) &&
                (entry.g || (entry.asid == asid));
endmodule

/* tmo_decode.sv */
// Decoder for the four TLB maintenance instructions
`timescale 1ns/1ns
`include "tmo_consts.svh"
module tmo_decode (
   // Instruction word
   input wire logic [31:0] word,
   // Decoded operation
   output tmo_pkg::tmo_op_e op
);
   import tmo_pkg::*;

   logic sys_op;

   assign sys_op = (word[31:26] == `TMO_OPC_SYS) && word[25] &&
                   (word[24:6] == `TMO_ZERO19);

   always_comb begin
      op = OP_NONE;
      if (sys_op) begin
         unique case (word[5:0])
            `TMO_FN_PROBE: op = OP_PROBE;
            `TMO_FN_READ: op = OP_READ;
            `TMO_FN_WIDX: op = OP_WIDX;
            `TMO_FN_WRND: op = OP_WRND;
            default: op = OP_NONE;
         endcase
      end
   end
endmodule

/* tmo_unit.sv */
// TLB maintenance unit: staging registers, TLB array, APB slave
// Functional notes
// RULE1 - Probe is opcode 010000, operation bit one, 19 zeros, function 001000.
// RULE2 - Probe hit writes entry number to index bits 5..0, upper 26 zero.
// RULE3 - Probe miss sets index bit 31 and clears the next 25 bits.
// RULE4 - Multiple matches give no defined result; next access unspecified.
// RULE5 - Indexed read loads mask, entry high (mask cleared) and both lows.
// RULE6 - Indexed read copies the single global bit into both low registers.
// RULE7 - Software keeps index within implemented entries for read and write.
// RULE8 - Indexed write stores mask, masked high and both lows at index.
// RULE9 - Written global bit is the AND of both low global bits.
// RULE10 - Random write stores the same fields at the random register slot.
// RULE11 - Unusable coprocessor raises exception, nothing else changes.
// RULE12 - Read, indexed write, random write use functions 01, 02, 06.
`timescale 1ns/1ns
`include "tmo_consts.svh"
module tmo_unit #(
   parameter int ENTRIES = 32
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Pipeline instruction port
   input wire logic op_valid,
   input wire logic [31:0] op_word,
   output logic op_done,
   output logic cu_exc,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import tmo_pkg::*;

   localparam logic [5:0] LAST = 6'(ENTRIES - 1);

   typedef struct packed {
      logic [31:0] entry_high;
      logic [31:0] low_even;
      logic [31:0] low_odd;
      logic [31:0] page_mask;
      logic [31:0] index;
      logic [5:0] random;
      logic cu_enable;
      logic done;
      logic cu_exc;
      logic [31:0] prdata;
      logic slverr;
      tmo_entry_s [ENTRIES-1:0] tlb;
   } tmo_state_s;

   tmo_state_s state_q;
   tmo_state_s state_d;
   tmo_op_e op;
   logic [ENTRIES-1:0] hit_vec;
   logic hit_any;
   logic [5:0] hit_idx;
   logic [5:0] idx;
   logic idx_ok;
   logic rnd_ok;
   tmo_entry_s staged;
   tmo_entry_s rd_ent;

   // ****************************************************************
   // Decode and probe compare
   // ****************************************************************
   tmo_decode u_decode (
      .word(op_word),
      .op(op)
   );

   for (genvar i = 0; i < ENTRIES; i++) begin : g_match
      tmo_match u_match (
         .entry(state_q.tlb[i]),
         .vpn(state_q.entry_high[`TMO_VPN_HI:`TMO_VPN_LO]),
         .asid(state_q.entry_high[`TMO_ASID_HI:0]),
         .hit(hit_vec[i])
      );
   end

   // Lowest matching slot wins; several matches are not meaningful
   always_comb begin
      hit_any = 1'b0;
      hit_idx = 6'h00;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin // [RULE4]
            hit_any = 1'b1;
            hit_idx = 6'(i);
         end
      end
   end

   // ****************************************************************
   // Staged entry and selected entry
   // ****************************************************************
   assign idx = state_q.index[`TMO_IDX_HI:0];
   // Out-of-range slots read as zero and are not written, rather than aliased
   assign idx_ok = (32'(idx) < 32'(ENTRIES)); // [RULE7]
   assign rnd_ok = (32'(state_q.random) < 32'(ENTRIES));
   assign rd_ent = idx_ok ? state_q.tlb[idx] : '0;

   always_comb begin
      staged.mask = state_q.page_mask[`TMO_PM_HI:`TMO_VPN_LO];
      staged.vpn = state_q.entry_high[`TMO_VPN_HI:`TMO_VPN_LO] &
                   ~{7'h00, staged.mask}; // [RULE8]
      staged.asid = state_q.entry_high[`TMO_ASID_HI:0];
      staged.g = state_q.low_even[`TMO_G_BIT] &
                 state_q.low_odd[`TMO_G_BIT]; // [RULE9]
      staged.lo1 = state_q.low_odd[`TMO_LO_HI:1];
      staged.lo0 = state_q.low_even[`TMO_LO_HI:1];
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_d = state_q;
      state_d.done = 1'b0;
      state_d.cu_exc = 1'b0;

      // Free-running victim pointer, wraps within implemented slots
      if (state_q.random == 6'h00 || !rnd_ok) begin
         state_d.random = LAST;
      end else begin
         state_d.random = state_q.random - 6'h01;
      end

      // APB read data is captured in the setup cycle
      if (psel && !penable) begin
         state_d.slverr = 1'b0;
         unique case (paddr)
            `TMO_A_ENTRY_HIGH: state_d.prdata = state_q.entry_high;
            `TMO_A_LOW_EVEN: state_d.prdata = state_q.low_even;
            `TMO_A_LOW_ODD: state_d.prdata = state_q.low_odd;
            `TMO_A_PAGE_MASK: state_d.prdata = state_q.page_mask;
            `TMO_A_INDEX: state_d.prdata = state_q.index;
            `TMO_A_RANDOM: state_d.prdata = {26'h0, state_q.random};
            `TMO_A_CTRL: state_d.prdata = {31'h0, state_q.cu_enable};
            default: begin
               state_d.prdata = `TMO_ZERO_W;
               state_d.slverr = 1'b1;
            end
         endcase
      end

      // APB write takes effect in the access cycle
      if (psel && penable && pwrite) begin
         unique case (paddr)
            `TMO_A_ENTRY_HIGH: state_d.entry_high = pwdata & `TMO_WM_HIGH;
            `TMO_A_LOW_EVEN: state_d.low_even = pwdata & `TMO_WM_LOW;
            `TMO_A_LOW_ODD: state_d.low_odd = pwdata & `TMO_WM_LOW;
            `TMO_A_PAGE_MASK: state_d.page_mask = pwdata & `TMO_WM_MASK;
            `TMO_A_INDEX: state_d.index = pwdata & `TMO_WM_INDEX;
            `TMO_A_CTRL: state_d.cu_enable = pwdata[`TMO_CTRL_CU];
            default: ;
         endcase
      end

      // An instruction in the same cycle overrides a bus write
      if (op_valid && op != OP_NONE) begin // [RULE1] [RULE12]
         if (!state_q.cu_enable) begin
            state_d.cu_exc = 1'b1; // [RULE11]
         end else begin
            state_d.done = 1'b1;
            unique case (op)
               OP_PROBE: begin
                  if (hit_any) begin
                     state_d.index = {26'h0, hit_idx}; // [RULE2]
                  end else begin
                     // Low six bits keep their old, undefined value
                     state_d.index = {1'b1, 25'h0, idx}; // [RULE3]
                  end
               end
               OP_READ: begin
                  state_d.page_mask = {7'h00, rd_ent.mask, 13'h0000};
                  state_d.entry_high = {rd_ent.vpn &
                     ~{7'h00, rd_ent.mask}, 5'h00, rd_ent.asid}; // [RULE5]
                  state_d.low_odd = {6'h00, rd_ent.lo1, rd_ent.g};
                  state_d.low_even = {6'h00, rd_ent.lo0, rd_ent.g}; // [RULE6]
               end
               OP_WIDX: begin
                  if (idx_ok) begin
                     state_d.tlb[idx] = staged; // [RULE8]
                  end
               end
               OP_WRND: begin
                  if (rnd_ok) begin
                     state_d.tlb[state_q.random] = staged; // [RULE10]
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= '0;
         state_q.random <= LAST;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign op_done = state_q.done;
   assign cu_exc = state_q.cu_exc;
   assign prdata = state_q.prdata;
   assign pslverr = state_q.slverr;
   // Every access completes in its first access cycle
   assign pready = 1'b1;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   logic usable_op;
   assign usable_op = op_valid && state_q.cu_enable;

   probe_decode_a: assert property ( // [RULE1]
      (op_valid && op_word[31:26] == `TMO_OPC_SYS && op_word[25] &&
       op_word[24:6] == `TMO_ZERO19 && op_word[5:0] == `TMO_FN_PROBE)
      |-> op == OP_PROBE
   ) else $error("probe word not decoded");

   probe_hit_a: assert property ( // [RULE2]
      (usable_op && op == OP_PROBE && hit_any)
      |=> state_q.index == {26'h0, $past(hit_idx)}
   ) else $error("probe hit index wrong");

   probe_miss_a: assert property ( // [RULE3]
      (usable_op && op == OP_PROBE && !hit_any)
      |=> state_q.index[31] && state_q.index[30:6] == 25'h0
   ) else $error("probe miss index wrong");

   read_high_a: assert property ( // [RULE5]
      (usable_op && op == OP_READ)
      |=> (state_q.entry_high[`TMO_VPN_HI:`TMO_VPN_LO] &
           {7'h00, state_q.page_mask[`TMO_PM_HI:`TMO_VPN_LO]}) == 19'h0
   ) else $error("read left page mask bits in entry high");

   read_global_a: assert property ( // [RULE6]
      (usable_op && op == OP_READ && idx_ok)
      |=> state_q.low_even[0] == state_q.low_odd[0] &&
          state_q.low_even[0] == $past(rd_ent.g)
   ) else $error("global bit not copied to both lows");

   write_global_a: assert property ( // [RULE9]
      (usable_op && op == OP_WIDX && idx_ok)
      |=> state_q.tlb[$past(idx)].g ==
          ($past(state_q.low_even[0]) && $past(state_q.low_odd[0]))
   ) else $error("stored global bit is not the AND");

   random_slot_a: assert property ( // [RULE10]
      (usable_op && op == OP_WRND)
      |=> state_q.tlb[$past(state_q.random)] == $past(staged)
   ) else $error("random write went to the wrong slot");

   random_range_a: assert property ( // [RULE10]
      32'(state_q.random) < 32'(ENTRIES)
   ) else $error("random pointer out of range");

   unusable_trap_a: assert property ( // [RULE11]
      (op_valid && op != OP_NONE && !state_q.cu_enable && !psel)
      |=> cu_exc && !op_done && $stable(state_q.tlb) &&
          $stable(state_q.index) && $stable(state_q.entry_high)
   ) else $error("unusable coprocessor did not trap cleanly");

   wr_decode_a: assert property ( // [RULE12]
      (op_valid && op_word[31:25] == {`TMO_OPC_SYS, 1'b1} &&
       op_word[24:6] == `TMO_ZERO19)
      |-> ((op_word[5:0] == `TMO_FN_READ) == (op == OP_READ)) &&
          ((op_word[5:0] == `TMO_FN_WIDX) == (op == OP_WIDX)) &&
          ((op_word[5:0] == `TMO_FN_WRND) == (op == OP_WRND))
   ) else $error("read or write word not decoded");

   index_slot_a: assert property ( // [RULE8]
      (usable_op && op == OP_WIDX && idx_ok)
      |=> state_q.tlb[$past(idx)] == $past(staged)
   ) else $error("indexed write stored the wrong fields");

   read_fields_a: assert property ( // [RULE5]
      (usable_op && op == OP_READ && idx_ok)
      |=> state_q.page_mask[`TMO_PM_HI:`TMO_VPN_LO] == $past(rd_ent.mask) &&
          state_q.entry_high[`TMO_ASID_HI:0] == $past(rd_ent.asid) &&
          state_q.low_odd[`TMO_LO_HI:1] == $past(rd_ent.lo1) &&
          state_q.low_even[`TMO_LO_HI:1] == $past(rd_ent.lo0)
   ) else $error("read did not load the selected entry");

   quiet_word_a: assert property ( // [RULE1]
      (op_valid && op == OP_NONE) |=> !op_done && !cu_exc
   ) else $error("non maintenance word raised a pulse");

   usable_done_a: assert property ( // [RULE11]
      (op_valid && op != OP_NONE && state_q.cu_enable)
      |=> op_done && !cu_exc
   ) else $error("usable coprocessor op did not complete");
endmodule

/* tmo_pipe_model.sv */
// Pipeline model that issues system coprocessor instruction words
`timescale 1ns/1ns
module tmo_pipe_model (
   // Clock
   input wire logic mclk,
   // Instruction port
   output logic op_valid,
   output logic [31:0] op_word
);
   initial begin
      op_valid = 1'b0;
      op_word = 32'h5A5A5A5A;
   end
   // Caller stands just after a rising edge; word is taken at the next one
   task automatic issue(input logic [31:0] w);
      op_valid <= 1'b1;
      op_word <= w;
      @(posedge mclk);
   endtask
   // Released word toggles so a stale opcode never looks held
   task automatic idle();
      op_valid <= 1'b0;
      op_word <= ~op_word;
   endtask
endmodule

/* tb.sv */
// Self-checking testbench of the TLB maintenance unit
`timescale 1ns/1ns
`include "tmo_consts.svh"
module tb;
   localparam logic [31:0] W_PRB = {`TMO_OPC_SYS, 1'b1, `TMO_ZERO19, `TMO_FN_PROBE};
   localparam logic [31:0] W_RD = {`TMO_OPC_SYS, 1'b1, `TMO_ZERO19, `TMO_FN_READ};
   localparam logic [31:0] W_WI = {`TMO_OPC_SYS, 1'b1, `TMO_ZERO19, `TMO_FN_WIDX};
   localparam logic [31:0] W_WR = {`TMO_OPC_SYS, 1'b1, `TMO_ZERO19, `TMO_FN_WRND};
   logic mclk, reset, op_valid, op_done, cu_exc;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] op_word, pwdata, prdata, rd, seed, hi, msk, l0, l1, idx, g;
   logic er;
   int failures, checks;
   logic [31:0] ops [5];
   // ****************************************************************
   // Design and pipeline model
   // ****************************************************************
   tmo_unit #(.ENTRIES(32)) i_tmo_unit (.mclk(mclk), .reset(reset),
      .op_valid(op_valid), .op_word(op_word), .op_done(op_done),
      .cu_exc(cu_exc), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   tmo_pipe_model i_tmo_pipe_model (.mclk(mclk), .op_valid(op_valid),
      .op_word(op_word));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Low register as read back: data bits kept, global bit from the entry
   function automatic logic [31:0] exp_low(input logic [31:0] lo,
                                           input logic [31:0] gb);
      return (lo & 32'h03FFFFFE) | gb;
   endfunction
   task automatic close_out();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Called just after a rising edge; returns one idle edge after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never re-raises psel in this step
      @(posedge mclk);
   endtask
   task automatic op(input logic [31:0] w, input logic dn, input logic ex);
      i_tmo_pipe_model.issue(w);
      i_tmo_pipe_model.idle();
      @(negedge mclk);
      check({31'h0, op_done}, {31'h0, dn});
      check({31'h0, cu_exc}, {31'h0, ex});
      @(posedge mclk);
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      seed = 32'd70458;
      failures = 0;
      checks = 0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      ops = '{W_PRB, W_RD, W_WI, W_WR, 32'h42000108};
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      // Unmapped write must not unlock the coprocessor
      apb(1'b1, 8'h1C, 32'h00000001);
      check({31'h0, er}, 32'h00000001);
      apb(1'b1, `TMO_A_INDEX, 32'h00000005);
      apb(1'b1, `TMO_A_ENTRY_HIGH, 32'hFFFFE0FF);
      for (int i = 0; i < 5; i++) begin
         op(ops[i], 1'b0, i < 4);
      end
      apb(1'b0, `TMO_A_INDEX, 32'h0);
      check(rd, 32'h00000005);
      $display("test done: unusable coprocessor");
      apb(1'b1, `TMO_A_CTRL, 32'h00000001);
      for (int k = 0; k < 8; k++) begin
         idx = rnd() & 32'h1F;
         hi = {7'(k + 1), 25'(rnd())} & `TMO_WM_HIGH;
         msk = rnd() & `TMO_WM_MASK;
         l0 = rnd() & `TMO_WM_LOW;
         l1 = rnd() & `TMO_WM_LOW;
         if (k < 2) begin
            l0[0] = 1'b1;
            l1[0] = (k == 0);
         end
         g = {31'h0, l0[0] & l1[0]};
         apb(1'b1, `TMO_A_ENTRY_HIGH, hi);
         apb(1'b1, `TMO_A_PAGE_MASK, msk);
         apb(1'b1, `TMO_A_LOW_EVEN, l0);
         apb(1'b1, `TMO_A_LOW_ODD, l1);
         apb(1'b1, `TMO_A_INDEX, idx);
         // Write once, then probe with the masked key
         i_tmo_pipe_model.issue(k[0] ? W_WR : W_WI);
         i_tmo_pipe_model.idle();
         apb(1'b1, `TMO_A_ENTRY_HIGH, hi & ~msk);
         i_tmo_pipe_model.issue(W_PRB);
         i_tmo_pipe_model.idle();
         @(posedge mclk);
         apb(1'b0, `TMO_A_INDEX, 32'h0);
         if (!k[0]) begin
            check(rd, idx);
         end else begin
            check(rd & 32'hFFFFFFC0, 32'h0);
         end
         apb(1'b1, `TMO_A_ENTRY_HIGH, 32'h0);
         apb(1'b1, `TMO_A_PAGE_MASK, 32'h0);
         apb(1'b1, `TMO_A_LOW_EVEN, 32'h0);
         apb(1'b1, `TMO_A_LOW_ODD, 32'h0);
         op(W_RD, 1'b1, 1'b0);
         apb(1'b0, `TMO_A_ENTRY_HIGH, 32'h0);
         check(rd, hi & ~msk);
         apb(1'b0, `TMO_A_PAGE_MASK, 32'h0);
         check(rd, msk);
         apb(1'b0, `TMO_A_LOW_EVEN, 32'h0);
         check(rd, exp_low(l0, g));
         apb(1'b0, `TMO_A_LOW_ODD, 32'h0);
         check(rd, exp_low(l1, g));
      end
      $display("test done: write, probe and read");
      apb(1'b1, `TMO_A_ENTRY_HIGH, 32'hFE000000);
      op(W_PRB, 1'b1, 1'b0);
      apb(1'b0, `TMO_A_INDEX, 32'h0);
      check(rd & 32'hFFFFFFC0, 32'h80000000);
      $display("test done: probe miss");
      close_out();
   end
endmodule
